// >>> src/spisc_pkg.sv
package spisc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_DATA = 8'h08;
    localparam logic [7:0] OFF_PIN = 8'h0C;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_GIE = 8'h14;

    // Control register fields
    localparam int CTRL_IE = 7;
    localparam int CTRL_EN = 6;
    localparam int CTRL_BIT_ORDER_SELECT = 5;
    localparam int CTRL_MASTER_SELECT_BIT = 4;
    localparam int CTRL_CLOCK_POLARITY_SELECT = 3;
    localparam int CTRL_CLOCK_PHASE_SELECT = 2;
    localparam int CTRL_RATE = 0;

    // Status and mask fields
    localparam int STAT_TCF = 7;
    localparam int STAT_BUSY = 1;
    localparam int STAT_FAULT = 0;

    // Pin control fields
    localparam int PIN_SS_DIR = 0;
    localparam int PIN_MISO_DIR = 1;
    localparam int PIN_MOSI_DIR = 2;
    localparam int PIN_SCK_DIR = 3;
    localparam int PIN_SS_OUT = 4;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h81;
    localparam logic [4:0] PIN_RST = 5'h00;

    // Master clock timing: least half period of the base rate
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SCK_HALF_PS = 20000;
    localparam int HALF_BASE = (SCK_HALF_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [4:0] SCK_EDGES = 5'h10;
    localparam logic [2:0] BIT_LAST = 3'h7;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } spisc_st_e;

    typedef struct packed {
        logic o;
        logic oe;
    } spisc_pad_s;

    typedef struct packed {
        logic clock_polarity_select;
        logic clock_phase_select;
        logic bit_order_select;
    } spisc_fmt_s;

endpackage

// >>> src/spisc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module spisc_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Asynchronous levels in, synchronised levels out
    input wire logic [3:0] async_in,
    output logic [3:0] sync_out
);
    import spisc_pkg::*;

    typedef struct packed {
        logic [3:0] meta;
        logic [3:0] sync;
    } spisc_sync_s;

    spisc_sync_s s_r;
    spisc_sync_s s_nxt;

    always_comb begin
        s_nxt.meta = async_in;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{meta: 4'hF, sync: 4'hF};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.sync;
endmodule
`default_nettype wire

// >>> src/spisc_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module spisc_shifter (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clr,
    input wire logic load,
    input wire logic [7:0] tx_byte,
    input wire spisc_pkg::spisc_fmt_s fmt,
    // Serial side
    input wire logic sck_lvl,
    input wire logic din,
    output logic dout,
    // Results
    output logic done,
    output logic [7:0] rx_byte
);
    import spisc_pkg::*;

    typedef struct packed {
        logic sck_q;
        logic [7:0] rxs;
        logic [2:0] smpc;
        logic [2:0] shc;
        logic [7:0] tx;
        logic [7:0] rx;
        logic done;
        logic dout;
    } spisc_shf_s;

    spisc_shf_s s_r;
    spisc_shf_s s_nxt;

    always_comb begin
        logic edge_seen;
        logic samp;
        logic shft;
        logic [7:0] nb;
        logic [2:0] k;
        edge_seen = sck_lvl != s_r.sck_q;
        samp = edge_seen && ((sck_lvl == fmt.clock_polarity_select) == fmt.clock_phase_select);
        shft = edge_seen && ((sck_lvl == fmt.clock_polarity_select) != fmt.clock_phase_select);
        k = 3'h0;
        nb = fmt.bit_order_select ? {din, s_r.rxs[7:1]} : {s_r.rxs[6:0], din};
        s_nxt = s_r;
        s_nxt.sck_q = sck_lvl;
        s_nxt.done = 1'b0;
        // The byte to send is kept even while the counters are held clear
        if (load) begin
            s_nxt.tx = tx_byte;
        end
        if (clr) begin
            // Partial byte and bit counters are dropped
            s_nxt.rxs = 8'h00;
            s_nxt.smpc = 3'h0;
            s_nxt.shc = 3'h0;
        end else begin
            if (load) begin
                s_nxt.smpc = 3'h0;
                s_nxt.shc = 3'h0;
            end
            if (samp) begin
                s_nxt.rxs = nb;
                s_nxt.smpc = s_r.smpc + 3'h1;
                if (s_r.smpc == BIT_LAST) begin
                    s_nxt.rx = nb;
                    s_nxt.done = 1'b1;
                end
            end
            if (shft) begin
                s_nxt.shc = s_r.shc + 3'h1;
            end
        end
        // Late phase shows bit n after the (n+1)th leading edge
        k = fmt.clock_phase_select ? s_nxt.shc - 3'h1 : s_nxt.shc;
        s_nxt.dout = fmt.bit_order_select ? s_nxt.tx[k] : s_nxt.tx[BIT_LAST - k];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.dout;
    assign done = s_r.done;
    assign rx_byte = s_r.rx;
endmodule
`default_nettype wire

// >>> src/spisc_top.sv
// Overview of operation
// - In slave operation the select pin is always an input whatever its direction bit says.
// - Slave with select low is active and drives MISO only when its direction bit asks.
// - Slave with select high ignores serial data; only MISO may still be an output.
// - A rising select in slave operation resets bit counters and drops the partial byte.
// - The master-select bit sets master operation, where software picks the select direction.
// - Master with select as output drives it as a plain output that does not touch the port.
// - Select driven low while master with select as input clears master-select, making MOSI and SCK inputs.
// - That forced switch sets the transfer-complete flag and may raise the interrupt.
// - Control bit 7 enables the interrupt together with the flag, its mask bit and the global enable.
// - Control bit 6 enables the port; nothing is transferred while it is zero.
// - Control bit 5 set sends the least significant bit first, clear the most significant.
`timescale 1ns/1ps
`default_nettype none
module spisc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Link pins, input side
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    input wire logic ss_i,
    // Link pins, drive side
    output var spisc_pkg::spisc_pad_s sck_pad,
    output var spisc_pkg::spisc_pad_s mosi_pad,
    output var spisc_pkg::spisc_pad_s miso_pad,
    output var spisc_pkg::spisc_pad_s ss_pad,
    // Interrupt
    output logic irq
);
    import spisc_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic tcf;
        logic fault;
        logic [7:0] mask;
        logic [4:0] pin;
        logic gie;
        logic [31:0] prdata;
        spisc_st_e st;
        logic [5:0] div;
        logic [4:0] tog;
        logic sck_gen;
    } spisc_top_s;

    spisc_top_s s_r;
    spisc_top_s s_nxt;

    logic [3:0] pins_sync;
    logic sck_s;
    logic mosi_s;
    logic miso_s;
    logic ss_s;
    logic master;
    logic en;
    logic ss_high;
    logic fault_evt;
    logic setup;
    logic wr;
    logic hit;
    logic load;
    logic clr;
    logic shf_sck;
    logic shf_din;
    logic shf_dout;
    logic shf_done;
    logic [7:0] rx_byte;
    logic [5:0] half_last;
    spisc_fmt_s fmt;

    // All link inputs pass two flip-flops first
    spisc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({sck_i, mosi_i, miso_i, ss_i}),
        .sync_out(pins_sync)
    );

    assign sck_s = pins_sync[3];
    assign mosi_s = pins_sync[2];
    assign miso_s = pins_sync[1];
    assign ss_s = pins_sync[0];

    assign master = s_r.ctrl[CTRL_MASTER_SELECT_BIT];
    assign en = s_r.ctrl[CTRL_EN];
    assign ss_high = ss_s;
    assign fmt = '{clock_polarity_select: s_r.ctrl[CTRL_CLOCK_POLARITY_SELECT], clock_phase_select: s_r.ctrl[CTRL_CLOCK_PHASE_SELECT],
                   bit_order_select: s_r.ctrl[CTRL_BIT_ORDER_SELECT]};

    // Select pulled low while master with the pin as input
    assign fault_evt = en && master && !s_r.pin[PIN_SS_DIR] && !ss_s;

    // APB decode
    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    always_comb begin
        case (paddr)
            OFF_CTRL, OFF_STAT, OFF_DATA, OFF_PIN, OFF_MASK, OFF_GIE: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // A data write while idle queues the byte; in master it also starts the clock
    assign load = wr && (paddr == OFF_DATA) && s_r.st == ST_IDLE;

    // Half period of the generated clock, scaled by the rate field
    assign half_last = 6'((HALF_BASE << s_r.ctrl[CTRL_RATE +: 2]) - 1);

    // Shifter is held clear while disabled or while a slave is deselected
    assign clr = !en || (!master && ss_high) || fault_evt;
    assign shf_sck = master ? s_r.sck_gen : sck_s;
    assign shf_din = master ? miso_s : mosi_s;

    spisc_shifter u_shf (
        .pclk(pclk),
        .presetn(presetn),
        .clr(clr),
        .load(load),
        .tx_byte(pwdata[7:0]),
        .fmt(fmt),
        .sck_lvl(shf_sck),
        .din(shf_din),
        .dout(shf_dout),
        .done(shf_done),
        .rx_byte(rx_byte)
    );

    always_comb begin
        s_nxt = s_r;

        // Read data is captured in the setup phase
        if (setup && !pwrite) begin
            case (paddr)
                OFF_CTRL: s_nxt.prdata = {24'h000000, s_r.ctrl};
                OFF_STAT: s_nxt.prdata = {24'h000000, s_r.tcf, 5'h00,
                                          s_r.st == ST_RUN, s_r.fault};
                OFF_DATA: s_nxt.prdata = {24'h000000, rx_byte};
                OFF_PIN: s_nxt.prdata = {27'h0000000, s_r.pin};
                OFF_MASK: s_nxt.prdata = {24'h000000, s_r.mask};
                OFF_GIE: s_nxt.prdata = {31'h00000000, s_r.gie};
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end

        // Register writes
        if (wr) begin
            case (paddr)
                OFF_CTRL: s_nxt.ctrl = pwdata[7:0];
                OFF_STAT: begin
                    if (pwdata[STAT_TCF]) begin
                        s_nxt.tcf = 1'b0;
                    end
                    if (pwdata[STAT_FAULT]) begin
                        s_nxt.fault = 1'b0;
                    end
                end
                OFF_PIN: s_nxt.pin = pwdata[4:0];
                OFF_MASK: s_nxt.mask = pwdata[7:0];
                OFF_GIE: s_nxt.gie = pwdata[0];
                default: ;
            endcase
        end

        // Master clock sequencer
        case (s_r.st)
            ST_IDLE: begin
                s_nxt.sck_gen = s_nxt.ctrl[CTRL_CLOCK_POLARITY_SELECT];
                s_nxt.div = 6'h00;
                s_nxt.tog = 5'h00;
                if (load && master && en) begin
                    s_nxt.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!en || !master) begin
                    s_nxt.st = ST_IDLE;
                end else if (s_r.div == half_last) begin
                    s_nxt.div = 6'h00;
                    s_nxt.sck_gen = !s_r.sck_gen;
                    s_nxt.tog = s_r.tog + 5'h01;
                    if (s_r.tog == SCK_EDGES - 5'h01) begin
                        s_nxt.st = ST_IDLE;
                    end
                end else begin
                    s_nxt.div = s_r.div + 6'h01;
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase

        // Hardware events win over a clear in the same cycle
        if (shf_done) begin
            s_nxt.tcf = 1'b1;
        end
        if (fault_evt) begin
            s_nxt.ctrl[CTRL_MASTER_SELECT_BIT] = 1'b0;
            s_nxt.tcf = 1'b1;
            s_nxt.fault = 1'b1;
            s_nxt.st = ST_IDLE;
            s_nxt.sck_gen = s_r.ctrl[CTRL_CLOCK_POLARITY_SELECT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '{ctrl: CTRL_RST, tcf: 1'b0, fault: 1'b0, mask: MASK_RST,
                     pin: PIN_RST, gie: 1'b0, prdata: 32'h00000000,
                     st: ST_IDLE, div: 6'h00, tog: 5'h00, sck_gen: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // APB answers in the access phase with no wait state
    assign prdata = s_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Pin drivers; a slave never drives SCK, MOSI or select
    assign sck_pad.o = s_r.sck_gen;
    assign sck_pad.oe = en && master && s_r.pin[PIN_SCK_DIR];
    assign mosi_pad.o = shf_dout;
    assign mosi_pad.oe = en && master && s_r.pin[PIN_MOSI_DIR];
    assign miso_pad.o = shf_dout;
    assign miso_pad.oe = en && !master && s_r.pin[PIN_MISO_DIR];
    assign ss_pad.o = s_r.pin[PIN_SS_OUT];
    assign ss_pad.oe = master && s_r.pin[PIN_SS_DIR];

    // Interrupt needs the flag, its enable, the mask and the global enable
    assign irq = s_r.gie && s_r.ctrl[CTRL_IE] && s_r.tcf
                 && (s_r.mask[STAT_TCF] || (s_r.fault && s_r.mask[STAT_FAULT]));
endmodule
`default_nettype wire

// >>> dv/spisc_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module spisc_top_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Link pins
    input wire logic ss_i,
    input wire spisc_pkg::spisc_pad_s sck_pad,
    input wire spisc_pkg::spisc_pad_s mosi_pad,
    input wire spisc_pkg::spisc_pad_s ss_pad,
    // Interrupt
    input wire logic irq
);
    import spisc_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pwrite;
    sequence s_fault;
        $fell(ss_i) && sck_pad.oe && !ss_pad.oe ##1 !ss_i [*2];
    endsequence
    property p_fault_sck;
        s_fault |-> ##[1:3] !sck_pad.oe;
    endproperty
    a_fault_sck: assert property (p_fault_sck) else $error("sck driven after select fault");
    property p_fault_mosi;
        s_fault |-> ##[1:3] !mosi_pad.oe;
    endproperty
    a_fault_mosi: assert property (p_fault_mosi) else $error("mosi driven after select fault");
    property p_ss_out_keep;
        ss_pad.oe && sck_pad.oe && !ss_i && !wr |=> sck_pad.oe;
    endproperty
    a_ss_out_keep: assert property (p_ss_out_keep) else $error("select output hit the port");
    property p_master_by_write;
        !sck_pad.oe && !wr |=> !sck_pad.oe;
    endproperty
    a_master_by_write: assert property (p_master_by_write) else $error("sck driven unasked");
    property p_ss_dir_by_write;
        !ss_pad.oe && !wr |=> !ss_pad.oe;
    endproperty
    a_ss_dir_by_write: assert property (p_ss_dir_by_write) else $error("select driven unasked");
    property p_half;
        sck_pad.oe && $changed(sck_pad.o) |=> $stable(sck_pad.o) [*3];
    endproperty
    a_half: assert property (p_half) else $error("sck half period too short");
    property p_slverr;
        pslverr |-> psel && penable;
    endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr outside access phase");
    property p_prdata_hi;
        prdata[31:8] == 24'h000000;
    endproperty
    a_prdata_hi: assert property (p_prdata_hi) else $error("prdata upper bits set");
    c_fault: cover property (sck_pad.oe ##1 !sck_pad.oe);
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule
bind spisc_top spisc_top_monitor u_spisc_top_monitor (.pclk, .presetn, .psel, .penable,
    .pwrite, .prdata, .pslverr, .ss_i, .sck_pad, .mosi_pad, .ss_pad, .irq);
`default_nettype wire

// >>> dv/spisc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module spisc_far_end (
    // Wire levels
    input wire logic sck_w,
    input wire logic mosi_w,
    input wire logic miso_w,
    // Far side drive
    output logic sck_m,
    output logic mosi_m,
    output logic miso_m,
    output logic ss_m
);
    logic [7:0] stx_r;
    logic [7:0] srx_r;
    initial begin
        sck_m = 1'b0;
        mosi_m = 1'b0;
        ss_m = 1'b1;
        stx_r = 8'h00;
        srx_r = 8'h00;
    end
    assign miso_m = stx_r[7];
    // Slave role, mode 0; the filler bit keeps a released line moving
    always @(posedge sck_w) begin
        srx_r <= {srx_r[6:0], mosi_w};
    end
    always @(negedge sck_w) begin
        stx_r <= {stx_r[6:0], ~stx_r[7]};
    end
    task automatic load(input logic [7:0] b);
        stx_r = b;
    endtask
    // Master role: clock stands low outside frames
    task automatic xfer(input logic [7:0] tx, input int nb, input logic sel,
                        output logic [7:0] rx);
        rx = 8'h00;
        ss_m = ~sel;
        #48;
        for (int i = 0; i < nb; i++) begin
            mosi_m = tx[7 - i];
            #24 sck_m = 1'b1;
            rx = {rx[6:0], miso_w};
            #24 sck_m = 1'b0;
        end
        #24 ss_m = 1'b1;
        mosi_m = ~mosi_m;
        // Select stays high long enough to pass the port's synchroniser
        #48;
    endtask
endmodule
`default_nettype wire

// >>> dv/test_spi_select_and_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_spi_select_and_control;
    import spisc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [7:0] paddr, frx;
    logic [31:0] pwdata, prdata, rd;
    logic sck_i, mosi_i, miso_i, ss_i, sck_m, mosi_m, miso_m, ss_m;
    spisc_pad_s sck_pad, mosi_pad, miso_pad, ss_pad;
    int failures = 0;
    int n_compared = 0;
    assign sck_i = sck_pad.oe ? sck_pad.o : sck_m;
    assign mosi_i = mosi_pad.oe ? mosi_pad.o : mosi_m;
    assign miso_i = miso_pad.oe ? miso_pad.o : miso_m;
    assign ss_i = ss_pad.oe ? ss_pad.o : ss_m;
    spisc_top u_spisc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sck_i, .mosi_i, .miso_i, .ss_i, .sck_pad, .mosi_pad,
        .miso_pad, .ss_pad, .irq);
    spisc_far_end u_spisc_far_end (.sck_w(sck_i), .mosi_w(mosi_i), .miso_w(miso_i),
        .sck_m, .mosi_m, .miso_m, .ss_m);
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic results();
        $display("Compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        results();
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
        if (pready !== 1'b1) begin
            failures++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic poll(input logic [31:0] m);
        int n;
        rd = 32'h0;
        for (n = 0; n < 60 && (rd & m) == 32'h0; n++) apb(1'b0, OFF_STAT, 32'h0);
        if ((rd & m) == 32'h0) begin
            failures++;
            results();
        end
    endtask
    task automatic fx(input logic [7:0] tx, input int nb, input logic sel);
        u_spisc_far_end.xfer(tx, nb, sel, frx);
        @(posedge pclk);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("ctrl", OFF_CTRL, {24'h0, CTRL_RST});
        rdchk("mask", OFF_MASK, {24'h0, MASK_RST});
        rdchk("unmapped", 8'h3C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        fx(8'hA5, 8, 1'b1);
        rdchk("stat_off", OFF_STAT, 32'h0);
        apb(1'b1, OFF_DATA, 32'h3C);
        apb(1'b1, OFF_PIN, 32'h02);
        apb(1'b1, OFF_CTRL, 32'h40);
        fx(8'hA5, 8, 1'b1);
        chk("far_rx", 32'h3C, {24'h0, frx});
        chk("miso_oe", 32'h1, {31'h0, miso_pad.oe});
        rdchk("rx", OFF_DATA, 32'hA5);
        rdchk("stat", OFF_STAT, 32'h80);
        chk("irq_gie_off", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_STAT, 32'h81);
        fx(8'hFF, 3, 1'b1);
        fx(8'h5A, 8, 1'b1);
        rdchk("rx_resync", OFF_DATA, 32'h5A);
        apb(1'b1, OFF_STAT, 32'h81);
        fx(8'h33, 8, 1'b0);
        rdchk("rx_passive", OFF_DATA, 32'h5A);
        rdchk("stat_passive", OFF_STAT, 32'h0);
        apb(1'b1, OFF_CTRL, 32'h60);
        apb(1'b1, OFF_DATA, 32'h01);
        fx(8'h01, 8, 1'b1);
        rdchk("rx_lsb", OFF_DATA, 32'h80);
        chk("far_rx_lsb", 32'h80, {24'h0, frx});
        apb(1'b1, OFF_STAT, 32'h81);
        apb(1'b1, OFF_CTRL, 32'h50);
        apb(1'b1, OFF_PIN, 32'h1D);
        u_spisc_far_end.load(8'hC3);
        apb(1'b1, OFF_DATA, 32'h96);
        poll(32'h80);
        chk("far_srx", 32'h96, {24'h0, u_spisc_far_end.srx_r});
        rdchk("rx_master", OFF_DATA, 32'hC3);
        chk("ss_pad", 32'h3, {30'h0, ss_pad});
        apb(1'b1, OFF_PIN, 32'h0D);
        repeat (8) @(posedge pclk);
        rdchk("ctrl_ss_out", OFF_CTRL, 32'h50);
        rdchk("stat_ss_out", OFF_STAT, 32'h80);
        // Select driven high again before it turns into an input
        apb(1'b1, OFF_PIN, 32'h1D);
        apb(1'b1, OFF_STAT, 32'h81);
        apb(1'b1, OFF_GIE, 32'h1);
        apb(1'b1, OFF_PIN, 32'h0C);
        apb(1'b1, OFF_CTRL, 32'hD0);
        chk("sck_oe", 32'h1, {31'h0, sck_pad.oe});
        u_spisc_far_end.ss_m <= 1'b0;
        poll(32'h1);
        chk("stat_fault", 32'h81, rd);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("ctrl_fault", OFF_CTRL, 32'hC0);
        chk("pads_in", 32'h0, {30'h0, sck_pad.oe, mosi_pad.oe});
        u_spisc_far_end.ss_m <= 1'b1;
        apb(1'b1, OFF_STAT, 32'h81);
        chk("irq_clear", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_CTRL, 32'hD0);
        chk("sck_oe_again", 32'h1, {31'h0, sck_pad.oe});
        results();
    end
endmodule
`default_nettype wire
